// >>> include/scd_pkg.sv
package scd_pkg;
  // Instruction field positions
  localparam int COND_HI         = 31;
  localparam int COND_LO         = 28;
  localparam int CLASS_HI        = 27;
  localparam int CLASS_LO        = 24;
  localparam int OP_BIT          = 4;
  localparam int OPC_HI          = 23;
  localparam int OPC_LO          = 20;
  localparam int CRN_HI          = 19;
  localparam int CRN_LO          = 16;
  localparam int CRD_HI          = 15;
  localparam int CRD_LO          = 12;
  localparam int CPNUM_HI        = 11;
  localparam int CPNUM_LO        = 8;
  localparam int INFO_HI         = 7;
  localparam int INFO_LO         = 5;
  localparam int CRM_HI          = 3;
  localparam int CRM_LO          = 0;
  // Class codes in bits 27-24
  localparam logic [3:0] CLASS_SVC   = 4'hf;
  localparam logic [3:0] CLASS_COP   = 4'he;
  // Status word layout: flags in 31-28, mode in 1-0
  localparam logic [1:0] MODE_USER   = 2'h0;
  localparam logic [1:0] MODE_SVC    = 2'h3;
  localparam logic [31:0] SVC_VECTOR = 32'h0000_0008;
  localparam logic [31:0] RESET_PC   = 32'h0000_0000;
  localparam logic [31:0] WORD_STEP  = 32'h0000_0004;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam int COP_REGS        = 16;
  // Condition codes
  localparam logic [3:0] CC_EQ = 4'h0;
  localparam logic [3:0] CC_NE = 4'h1;
  localparam logic [3:0] CC_CS = 4'h2;
  localparam logic [3:0] CC_CC = 4'h3;
  localparam logic [3:0] CC_MI = 4'h4;
  localparam logic [3:0] CC_PL = 4'h5;
  localparam logic [3:0] CC_VS = 4'h6;
  localparam logic [3:0] CC_VC = 4'h7;
  localparam logic [3:0] CC_HI = 4'h8;
  localparam logic [3:0] CC_LS = 4'h9;
  localparam logic [3:0] CC_GE = 4'ha;
  localparam logic [3:0] CC_LT = 4'hb;
  localparam logic [3:0] CC_GT = 4'hc;
  localparam logic [3:0] CC_LE = 4'hd;
  localparam logic [3:0] CC_AL = 4'he;
  // Flag order within 4-bit group: N Z C V
  function automatic logic scd_cond_true(input logic [3:0] cc,
                                         input logic [3:0] nzcv);
    logic n;
    logic z;
    logic c;
    logic v;
    n = nzcv[3];
    z = nzcv[2];
    c = nzcv[1];
    v = nzcv[0];
    case (cc)
      CC_EQ: scd_cond_true = z;
      CC_NE: scd_cond_true = !z;
      CC_CS: scd_cond_true = c;
      CC_CC: scd_cond_true = !c;
      CC_MI: scd_cond_true = n;
      CC_PL: scd_cond_true = !n;
      CC_VS: scd_cond_true = v;
      CC_VC: scd_cond_true = !v;
      CC_HI: scd_cond_true = c && !z;
      CC_LS: scd_cond_true = !c || z;
      CC_GE: scd_cond_true = n == v;
      CC_LT: scd_cond_true = n != v;
      CC_GT: scd_cond_true = !z && (n == v);
      CC_LE: scd_cond_true = z || (n != v);
      CC_AL: scd_cond_true = 1'b1;
      default: scd_cond_true = 1'b0;
    endcase
  endfunction
endpackage

// >>> include/scd_cop_if.sv
interface scd_cop_if;
  logic        issue;
  logic [31:0] instr;
  modport core
  (
    output issue,
    output instr
  );
  modport cop
  (
    input issue,
    input instr
  );
endinterface

// >>> hdl/scd_core.sv
// Summary of operation
// - Supervisor call enters supervisor mode
// - Fetch resumes at vector 0x08
// - Next-word PC and flags saved in link
// - Low 24 comment bits are ignored
// - Coprocessor op runs only if condition true
// - No result awaited; core never stalls
// - Core decodes only bit 4, bits 31-24
// - Only number field meaning is fixed
// - Coprocessor applies opcode to sources, writes dest
// - Register specifiers select one of sixteen
// - Supervisor call after cop op runs normally
// - Coprocessor may queue issued operations
module scd_core
  import scd_pkg::*;
(
  input  wire logic        clock_in,       // Core clock
  input  wire logic        nrst_in,        // Async reset, low
  input  wire logic        instr_valid_in, // Instruction present
  input  wire logic [31:0] instr_in,       // Instruction word
  input  wire logic [3:0]  flags_in,       // Flag load value
  input  wire logic        flags_load_in,  // Load flags strobe
  output logic             fetch_ready_out,// Accepting instructions
  output logic [31:0]      pc_out,         // Program counter
  output logic [1:0]       mode_out,       // Processor mode
  output logic [3:0]       flags_out,      // Current flags
  output logic [31:0]      link_out,       // Supervisor link register
  output logic             trap_out,       // Trap taken pulse
  output logic             undef_out,      // Undefined trap pulse
  scd_cop_if.core          cop             // Coprocessor side
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  // Gray order along the usual kinds
  typedef enum logic [1:0] {
    SCD_KIND_NONE = 2'h0,
    SCD_KIND_SVC  = 2'h1,
    SCD_KIND_OP   = 2'h3,
    SCD_KIND_XFER = 2'h2
  } scd_kind_t;

  // One record holds every bit of core state
  typedef struct packed {
    logic        ready;
    logic [31:0] pc;
    logic [1:0]  mode;
    logic [3:0]  flags;
    logic [31:0] link;
    logic        trap;
    logic        undef;
    logic        issue;
    logic [31:0] cop_word;
  } scd_core_state_t;

  scd_core_state_t st_reg;
  scd_core_state_t st_next;

  logic [3:0]  cond_field;
  logic [3:0]  cls;
  logic        op_bit;
  logic        pass;
  scd_kind_t   kind;
  logic [31:0] pc_plus;
  logic [31:0] link_word;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  // Only top byte and bit 4
  assign cond_field = instr_in[COND_HI:COND_LO];
  assign cls        = instr_in[CLASS_HI:CLASS_LO];
  assign op_bit     = instr_in[OP_BIT];

  // Condition check on flags
  // Flags before this edge, so a same-edge load is not seen
  assign pass = scd_cond_true(cond_field, st_reg.flags);

  // ------------------------------------------------------------
  // Class select
  // ------------------------------------------------------------
  // A failed condition leaves the word as a plain pc advance
  always_comb
  begin
    kind = SCD_KIND_NONE;
    if (instr_valid_in && pass)
    begin
      case (cls)
        CLASS_SVC:
        begin
          kind = SCD_KIND_SVC;
        end
        CLASS_COP:
        begin
          if (op_bit)
          begin
            // Register transfers are outside this block
            kind = SCD_KIND_XFER;
          end
          else
          begin
            kind = SCD_KIND_OP;
          end
        end
        default:
        begin
          // Other classes belong to other decoders
          kind = SCD_KIND_NONE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Return word
  // ------------------------------------------------------------
  // Next word, flags and mode
  // Word address is only 26 bits; the top nibble carries flags
  assign pc_plus   = st_reg.pc + WORD_STEP;
  assign link_word = {st_reg.flags, pc_plus[27:2], st_reg.mode};

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    st_next       = st_reg;
    st_next.ready = 1'b1;
    st_next.trap  = 1'b0;
    st_next.undef = 1'b0;
    st_next.issue = 1'b0;
    if (flags_load_in)
    begin
      st_next.flags = flags_in;
    end
    if (instr_valid_in)
    begin
      // Skipped words still advance
      st_next.pc = pc_plus;
    end
    case (kind)
      SCD_KIND_SVC:
      begin
        // No look-back at the word before
        st_next.link = link_word;
        st_next.mode = MODE_SVC;
        st_next.pc   = SVC_VECTOR;
        st_next.trap = 1'b1;
      end
      SCD_KIND_OP:
      begin
        // Fire and forget, no wait state
        st_next.issue    = 1'b1;
        st_next.cop_word = instr_in;
      end
      SCD_KIND_XFER:
      begin
        // Transfer forms are flagged, not executed
        st_next.undef = 1'b1;
      end
      default:
      begin
        // Words outside this block only advance the pc
        st_next.undef = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // Leaves reset in supervisor mode with ready low
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      st_reg       <= '0;
      st_reg.pc    <= RESET_PC;
      st_reg.mode  <= MODE_SVC;
      st_reg.flags <= FLAGS_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Ready is a flop, so it rises one edge after reset
  assign fetch_ready_out = st_reg.ready;
  assign pc_out          = st_reg.pc;
  assign mode_out        = st_reg.mode;
  assign flags_out       = st_reg.flags;
  assign link_out        = st_reg.link;
  assign trap_out        = st_reg.trap;
  assign undef_out       = st_reg.undef;
  assign cop.issue       = st_reg.issue;
  assign cop.instr       = st_reg.cop_word;
endmodule

// >>> hdl/scd_coproc.sv
module scd_coproc
  import scd_pkg::*;
#(
  parameter logic [3:0] MY_NUMBER = 4'h1  // Hardware-assigned number
)
(
  input  wire logic        clock_in,    // Core clock
  input  wire logic        nrst_in,     // Async reset, low
  input  wire logic [3:0]  rd_sel_in,   // Register read select
  output logic [31:0]      rd_data_out, // Selected register value
  output logic             done_out,    // Operation completed pulse
  output logic             busy_out,    // Operation pending
  scd_cop_if.cop           cop          // Core side
);
  typedef struct packed {
    logic [COP_REGS-1:0][31:0] regs;
    logic        pend;
    logic [31:0] word;
    logic        done;
    logic [31:0] rd;
  } scd_cop_state_t;

  scd_cop_state_t st_reg;
  scd_cop_state_t st_next;
  logic [31:0]    a;
  logic [31:0]    b;
  logic [31:0]    res;

  assign a = st_reg.regs[st_reg.word[CRN_HI:CRN_LO]];
  assign b = st_reg.regs[st_reg.word[CRM_HI:CRM_LO]];

  always_comb
  begin
    case (st_reg.word[OPC_HI:OPC_LO])
      4'h0:    res = a + b;
      4'h1:    res = a - b;
      4'h2:    res = a & b;
      4'h3:    res = a | b;
      4'h4:    res = a ^ b;
      4'h5:    res = a << st_reg.word[INFO_HI:INFO_LO];
      default: res = a;
    endcase
  end

  always_comb
  begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    st_next.rd   = st_reg.regs[rd_sel_in];
    // One-deep queue, runs a cycle later
    if (st_reg.pend)
    begin
      st_next.regs[st_reg.word[CRD_HI:CRD_LO]] = res;
      st_next.pend = 1'b0;
      st_next.done = 1'b1;
    end
    if (cop.issue && cop.instr[CPNUM_HI:CPNUM_LO] == MY_NUMBER)
    begin
      st_next.pend = 1'b1;
      st_next.word = cop.instr;
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign rd_data_out = st_reg.rd;
  assign done_out    = st_reg.done;
  assign busy_out    = st_reg.pend;
endmodule

// >>> verification/scd_cop_asserts.sv
module scd_cop_asserts
  import scd_pkg::*;
(
  input  wire logic        clock_in, // Core clock
  input  wire logic        nrst_in,  // Async reset, low
  input  wire logic        issue,    // Issue pulse
  input  wire logic [31:0] instr     // Issued word
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Issue channel checks
  // ----------------------------------------
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!nrst_in);
  property p_cls;
    issue |-> instr[CLASS_HI:CLASS_LO] == CLASS_COP;
  endproperty
  a_cls: assert property (p_cls) else $error("issued non-cop word");
  property p_bit4;
    issue |-> !instr[OP_BIT];
  endproperty
  a_bit4: assert property (p_bit4) else $error("issued transfer");
  property p_cond;
    issue |-> instr[COND_HI:COND_LO] != 4'hf;
  endproperty
  a_cond: assert property (p_cond) else $error("never-code issued");
  // Word stands between issues so any listener may decode late
  property p_hold;
    !issue |-> $stable(instr);
  endproperty
  a_hold: assert property (p_hold) else $error("word moved");
  property p_quiet;
    $rose(nrst_in) |-> !issue ##1 !issue;
  endproperty
  a_quiet: assert property (p_quiet) else $error("early issue");
  // No stale word may be seen by a listener after reset
  property p_clear;
    $rose(nrst_in) |-> instr == 32'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("word not clear");
  c_issue: cover property (issue);
  c_b2b: cover property (issue ##1 issue);
  c_gap: cover property ($fell(issue));
endmodule

// >>> verification/swi_and_coproc_op_decode_tb.sv
module swi_and_coproc_op_decode_tb
  import scd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        valid = 1'b0;
  logic        fl_ld = 1'b0;
  logic [3:0]  fl = 4'h0;
  logic [31:0] w = 32'h0;
  logic        rdy, trap, undef, busy7, done7, busy1;
  logic [1:0]  mode;
  logic [3:0]  flg;
  logic [31:0] pc, link;
  int          checked = 0;
  int          miscompares = 0;
  // ----------------------------------------
  // Core, two listeners, checker
  // ----------------------------------------
  always #2.5 clock_in = ~clock_in;
  scd_cop_if u_cop_if ();
  scd_core u_scd_core (.clock_in(clock_in), .nrst_in(nrst_in),
    .instr_valid_in(valid), .instr_in(w), .flags_in(fl),
    .flags_load_in(fl_ld), .fetch_ready_out(rdy), .pc_out(pc),
    .mode_out(mode), .flags_out(flg), .link_out(link), .trap_out(trap),
    .undef_out(undef), .cop(u_cop_if.core));
  scd_coproc #(.MY_NUMBER(4'h7)) u_scd_coproc (.clock_in(clock_in),
    .nrst_in(nrst_in), .rd_sel_in(4'h0), .rd_data_out(),
    .done_out(done7), .busy_out(busy7), .cop(u_cop_if.cop));
  scd_coproc #(.MY_NUMBER(4'h1)) u_scd_coproc_b (.clock_in(clock_in),
    .nrst_in(nrst_in), .rd_sel_in(4'h0), .rd_data_out(),
    .done_out(), .busy_out(busy1), .cop(u_cop_if.cop));
  scd_cop_asserts u_scd_cop_asserts (.clock_in(clock_in),
    .nrst_in(nrst_in), .issue(u_cop_if.issue), .instr(u_cop_if.instr));
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic step();
    @(posedge clock_in);
    #1;
  endtask
  task automatic exec(input logic [31:0] i);
    valid = 1'b1;
    w = i;
    step();
  endtask
  task automatic setfl(input logic [3:0] f);
    fl_ld = 1'b1;
    fl = f;
    step();
    fl_ld = 1'b0;
  endtask
  task automatic t_svc();
    setfl(4'ha);
    check({28'h0, flg}, 32'ha);
    exec(32'hef123456);
    valid = 1'b0;
    check(pc, SVC_VECTOR);
    check({30'h0, mode}, {30'h0, MODE_SVC});
    check({31'h0, trap}, 32'h1);
    check(link, {4'ha, 26'h1, MODE_SVC});
    step();
    exec(32'hef000000);
    valid = 1'b0;
    check(link, {4'ha, 26'h3, MODE_SVC});
    check(pc, SVC_VECTOR);
  endtask
  task automatic t_cop();
    setfl(4'h4);
    exec(32'h0e0a1702);
    valid = 1'b0;
    check(pc, 32'hc);
    check({31'h0, u_cop_if.issue}, 32'h1);
    check(u_cop_if.instr, 32'h0e0a1702);
    step();
    check({30'h0, busy7, busy1}, 32'h2);
    step();
    check({31'h0, done7}, 32'h1);
  endtask
  task automatic t_skip();
    setfl(4'h0);
    exec(32'h0e0a1702);
    valid = 1'b0;
    check(pc, 32'h10);
    check({31'h0, u_cop_if.issue}, 32'h0);
  endtask
  task automatic t_undef();
    step();
    exec(32'hee0a1712);
    valid = 1'b0;
    check({31'h0, undef}, 32'h1);
    check({31'h0, u_cop_if.issue}, 32'h0);
  endtask
  task automatic t_seq();
    step();
    exec(32'hee0a1702);
    check({31'h0, u_cop_if.issue}, 32'h1);
    exec(32'hef000000);
    valid = 1'b0;
    check({31'h0, trap, undef}, 32'h2);
    check(pc, SVC_VECTOR);
  endtask
  task automatic print_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clock_in);
    #1;
    nrst_in = 1'b1;
    step();
    check({31'h0, rdy}, 32'h1);
    t_svc();
    t_cop();
    t_skip();
    t_undef();
    t_seq();
    print_verdict();
  end
  // Whole sequence needs well under a microsecond
  initial
  begin
    #5000;
    miscompares++;
    print_verdict();
  end
endmodule
